/* common/pbm_pkg.sv */
// Purpose: Shared constants and types of the pixel bus mux block.
// Assumes: APB byte offsets, 32-bit pixel port, 8-bit VGA port.
// Notes:   Mux codes are register bits 5..0; bits 7..6 ignored.
// Overview of operation
// - After reset the block runs in mode 0, VGA pass-through from VGA bus.
// - Pass-through select restores clock, control and mask defaults.
// - Pass-through samples on first clock input; other modes on shift clock.
// - Normal modes take 8/16/32-bit buses, modes 1-3 also 4-bit; low bits.
// - Mode 1: one-bit pixel is address bit 0, page gives upper seven.
// - Mode 2: two-bit pixel is low address, page gives upper six.
// - Mode 3: four-bit pixel is low address, page gives upper four.
// - Mode 4: eight-bit pixel is whole address, page ignored.
// - All normal modes and direct modes 6c/6d support little or big endian order.
// - Nibble mode only when nibble enable set and split enable clear.
// - Nibble mode overrides every mode and ignores the mux register.
// - Flag picks low or high nibble of four bytes; page gives upper four.
// - Direct colour has the same pipeline delay as overlay and controls.
// - Zero overlay shows direct colour; nonzero overlay shows palette.
// - Mode 6a takes 5-5-5 colour plus one overlay bit.
// - Mode 6b takes 5-6-5 colour with overlay disabled.
// - Modes 6c and 6d take two words per load, bits 0-15 first unless big endian is set.
// - Modes 6e and 6f take 8-bit colours plus 8 overlay bits, reversed.
// - 16-bit colour fields are left aligned, low bits forced to zero.
// - Modes 6a/6c: page fills upper overlay bits; mask can force zero.
// - Modes 6e/6f colour inputs are 8-bit; palette follows 8/6 select.
// - Writing 2Dh to mux control enters pass-through, same as reset.
// - One shift clock edge latches all groups; lowest group shown first unless big endian is set.
// - Mux bits 5..0 select mode and width; bits 6 and 7 ignored.
package pbm_pkg;
  localparam logic [7:0] OFF_MUX  = 8'h00;
  localparam logic [7:0] OFF_GEN  = 8'h04;
  localparam logic [7:0] OFF_PAGE = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;
  localparam logic [7:0] OFF_ICLK = 8'h10;
  localparam logic [7:0] OFF_OCLK = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;

  localparam logic [7:0] MUX_RST  = 8'h2d;
  localparam logic [7:0] GEN_RST  = 8'h00;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hff;
  localparam logic [7:0] ICLK_RST = 8'h00;
  localparam logic [7:0] OCLK_RST = 8'h36;

  localparam int GEN_W8   = 1;
  localparam int GEN_SPLIT_TRANSFER_ENABLE = 2;
  localparam int GEN_SNM  = 3;
  localparam int GEN_BIG  = 5;

  localparam logic [5:0] MUX_VGA = 6'h2d;
  localparam logic [5:0] MUX_6A  = 6'h08;
  localparam logic [5:0] MUX_6B  = 6'h09;
  localparam logic [5:0] MUX_6C  = 6'h0a;
  localparam logic [5:0] MUX_6D  = 6'h0b;
  localparam logic [5:0] MUX_6E  = 6'h0e;
  localparam logic [5:0] MUX_6F  = 6'h0d;
  localparam logic [3:0] MUX_P1  = 4'h4;
  localparam logic [3:0] MUX_P2  = 4'h5;
  localparam logic [3:0] MUX_P4  = 4'h6;
  localparam logic [3:0] MUX_P8  = 4'h7;
  localparam logic [1:0] MUX_RSV = 2'h3;

  typedef enum logic [10:0] {
    MODE_VGA = 11'h001,
    MODE_P1  = 11'h002,
    MODE_P2  = 11'h004,
    MODE_P4  = 11'h008,
    MODE_P8  = 11'h010,
    MODE_NIB = 11'h020,
    MODE_6A  = 11'h040,
    MODE_6B  = 11'h080,
    MODE_6E  = 11'h100,
    MODE_6F  = 11'h200,
    MODE_BAD = 11'h400
  } pbm_mode_t;
endpackage

/* common/pbm_pix_if.sv */
`timescale 1ns/1ps
// Purpose: Carries load data and group layout to the dot-rate shifter.
// Assumes: One pclk domain; load and dot are one-cycle strobes.
// Notes:   gsh is log2 of the group width in bits.
interface pbm_pix_if;
  logic        load;
  logic        dot;
  logic        big;
  logic [31:0] data;
  logic [2:0]  gsh;
  logic [5:0]  ngrp;
  logic [31:0] pix;
  logic        pix_vld;
  modport ctl (output load, dot, big, data, gsh, ngrp,
               input  pix, pix_vld);
  modport shf (input  load, dot, big, data, gsh, ngrp,
               output pix, pix_vld);
endinterface

/* src/pbm_shifter.sv */
`timescale 1ns/1ps
// Purpose: Holds one bus load and hands out one pixel group per dot.
// Assumes: gsh and ngrp describe a load of at most 32 bits.
// Notes:   A load and a dot in the same cycle emit the first group (the top one if big) at once.
module pbm_shifter (
  input logic pclk,
  input logic presetn,
  pbm_pix_if.shf sif
);
  logic [31:0] word_q;
  logic [5:0]  idx_q;
  logic [31:0] pix_q;
  logic        vld_q;

  wire [5:0]  cur_idx  = sif.load ? 6'h00 : idx_q;
  wire [31:0] cur_word = sif.load ? sif.data : word_q;
  wire        more     = cur_idx < sif.ngrp;
  // Big endian walks the groups from the top
  wire [5:0]  sel = sif.big ? 6'(sif.ngrp - 6'h01 - cur_idx)
                            : cur_idx;
  wire [10:0] amt = {5'h00, sel} << sif.gsh;
  wire [63:0] wmask = ~(64'hffff_ffff_ffff_ffff << (7'h01 << sif.gsh));
  wire [31:0] grp = (cur_word >> amt) & wmask[31:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= 32'h0;
      idx_q  <= 6'h00;
      pix_q  <= 32'h0;
      vld_q  <= 1'b0;
    end else begin
      if (sif.load)
        word_q <= sif.data;
      vld_q <= sif.dot & more;
      if (sif.dot && more) begin
        pix_q <= grp;
        idx_q <= cur_idx + 6'h01;
      end else if (sif.load) begin
        idx_q <= 6'h00;
      end
    end
  end

  assign sif.pix     = pix_q;
  assign sif.pix_vld = vld_q;

  property p_first_group;
    @(posedge pclk) disable iff (!presetn)
    (sif.dot && sif.load && !sif.big && sif.gsh == 3'h3)
      |=> (sif.pix_vld && sif.pix[7:0] == $past(sif.data[7:0]));
  endproperty
  a_first_group: assert property (p_first_group)
    else $error("first group of a load not emitted first");
endmodule

/* src/pbm_top.sv */
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Purpose: Pixel bus mux and mode selector feeding palette and DACs.
// Assumes: All pins asynchronous to pclk; palette RAM answers pal_addr
//          combinationally on pal_data.
// Notes:   Clock generation and split transfers are outside this block.
module pbm_top (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        first_clock_input,
  input  logic        shift_clock,
  input  logic        pixel_dot_clock,
  input  logic        split_or_nibble_flag,
  input  logic [31:0] pix_bus,
  input  logic [7:0]  vga_bus,
  input  logic        blank_n,
  input  logic        hsync_n,
  input  logic        vsync_n,
  input  logic [23:0] pal_data,
  output logic [7:0]  pal_addr,
  output logic [7:0]  dac_red,
  output logic [7:0]  dac_green,
  output logic [7:0]  dac_blue,
  output logic        dac_blank_n,
  output logic        dac_hsync_n,
  output logic        dac_vsync_n
);
  // Pin synchronisers
  logic [46:0] sync_a_q;
  logic [46:0] sync_b_q;
  logic [2:0]  clk_prev_q;

  wire [46:0] pins_raw = {first_clock_input, shift_clock, pixel_dot_clock,
                          split_or_nibble_flag, blank_n, hsync_n, vsync_n,
                          vga_bus, pix_bus};
  wire [31:0] pix_s  = sync_b_q[31:0];
  wire [7:0]  vga_s  = sync_b_q[39:32];
  wire [2:0]  ctl_s  = sync_b_q[42:40];
  wire        flag_s = sync_b_q[43];
  wire        c0_rise = sync_b_q[46] & ~clk_prev_q[2];
  wire        sc_rise = sync_b_q[45] & ~clk_prev_q[1];
  wire        dc_rise = sync_b_q[44] & ~clk_prev_q[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_q   <= 47'h0;
      sync_b_q   <= 47'h0;
      clk_prev_q <= 3'h0;
    end else begin
      sync_a_q   <= pins_raw;
      sync_b_q   <= sync_a_q;
      clk_prev_q <= sync_b_q[46:44];
    end
  end

  // Register file
  logic [7:0]  mux_q;
  logic [7:0]  gen_q;
  logic [7:0]  page_q;
  logic [7:0]  mask_q;
  logic [7:0]  iclk_q;
  logic [7:0]  oclk_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  pbm_pkg::pbm_mode_t mode_c;

  wire sel_setup = psel & ~penable;
  wire hit_mux   = paddr == pbm_pkg::OFF_MUX;
  wire hit_gen   = paddr == pbm_pkg::OFF_GEN;
  wire hit_page  = paddr == pbm_pkg::OFF_PAGE;
  wire hit_mask  = paddr == pbm_pkg::OFF_MASK;
  wire hit_iclk  = paddr == pbm_pkg::OFF_ICLK;
  wire hit_oclk  = paddr == pbm_pkg::OFF_OCLK;
  wire hit_stat  = paddr == pbm_pkg::OFF_STAT;
  wire addr_hit  = hit_mux | hit_gen | hit_page | hit_mask |
                   hit_iclk | hit_oclk | hit_stat;
  wire wr_en     = psel & penable & pwrite & pready_q & ~pslverr_q;
  // Bits 7..6 take no part in the pass-through match
  wire vga_wr    = wr_en & hit_mux &
                   (pwdata[5:0] == pbm_pkg::MUX_VGA);

  wire [7:0] rd_b = hit_mux  ? mux_q  :
                    hit_gen  ? gen_q  :
                    hit_page ? page_q :
                    hit_mask ? mask_q :
                    hit_iclk ? iclk_q :
                    hit_oclk ? oclk_q : 8'h00;
  wire [31:0] rd_c = hit_stat ? {21'h0, mode_c} : {24'h0, rd_b};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= sel_setup;
      pslverr_q <= sel_setup & ~addr_hit;
      if (sel_setup)
        prdata_q <= rd_c;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_q  <= pbm_pkg::MUX_RST;
      gen_q  <= pbm_pkg::GEN_RST;
      page_q <= pbm_pkg::PAGE_RST;
      mask_q <= pbm_pkg::MASK_RST;
      iclk_q <= pbm_pkg::ICLK_RST;
      oclk_q <= pbm_pkg::OCLK_RST;
    end else begin
      if (wr_en && hit_mux)
        mux_q <= pwdata[7:0];
      if (wr_en && hit_page)
        page_q <= pwdata[7:0];
      if (vga_wr) begin
        gen_q  <= pbm_pkg::GEN_RST;
        mask_q <= pbm_pkg::MASK_RST;
        iclk_q <= pbm_pkg::ICLK_RST;
        oclk_q <= pbm_pkg::OCLK_RST;
      end else begin
        if (wr_en && hit_gen)
          gen_q <= pwdata[7:0];
        if (wr_en && hit_mask)
          mask_q <= pwdata[7:0];
        if (wr_en && hit_iclk)
          iclk_q <= pwdata[7:0];
        if (wr_en && hit_oclk)
          oclk_q <= pwdata[7:0];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // Mode decode
  wire [5:0] mux6   = mux_q[5:0];
  wire       nib_en = gen_q[pbm_pkg::GEN_SNM] &
                      ~gen_q[pbm_pkg::GEN_SPLIT_TRANSFER_ENABLE];
  wire       big    = gen_q[pbm_pkg::GEN_BIG];
  wire       w8     = gen_q[pbm_pkg::GEN_W8];

  // Nibble enable is checked first so the mux register cannot win
  assign mode_c =
    nib_en                               ? pbm_pkg::MODE_NIB :
    (mux6 == pbm_pkg::MUX_VGA)           ? pbm_pkg::MODE_VGA :
    (mux6[5:2] == pbm_pkg::MUX_P1)       ? pbm_pkg::MODE_P1  :
    (mux6[5:2] == pbm_pkg::MUX_P2)       ? pbm_pkg::MODE_P2  :
    (mux6[5:2] == pbm_pkg::MUX_P4)       ? pbm_pkg::MODE_P4  :
    (mux6[5:2] == pbm_pkg::MUX_P8 &&
     mux6[1:0] != pbm_pkg::MUX_RSV)      ? pbm_pkg::MODE_P8  :
    (mux6 == pbm_pkg::MUX_6A ||
     mux6 == pbm_pkg::MUX_6C)            ? pbm_pkg::MODE_6A  :
    (mux6 == pbm_pkg::MUX_6B ||
     mux6 == pbm_pkg::MUX_6D)            ? pbm_pkg::MODE_6B  :
    (mux6 == pbm_pkg::MUX_6E)            ? pbm_pkg::MODE_6E  :
    (mux6 == pbm_pkg::MUX_6F)            ? pbm_pkg::MODE_6F  :
                                           pbm_pkg::MODE_BAD;

  // Group layout per mode
  logic [2:0] gsh_c;
  logic [5:0] ngrp_c;

  always_comb begin
    gsh_c  = 3'h0;
    ngrp_c = 6'h00;
    case (mode_c)
      pbm_pkg::MODE_VGA: begin
        gsh_c  = 3'h3;
        ngrp_c = 6'h01;
      end
      pbm_pkg::MODE_P1: begin
        gsh_c  = 3'h0;
        ngrp_c = 6'h04 << mux6[1:0];
      end
      pbm_pkg::MODE_P2: begin
        gsh_c  = 3'h1;
        ngrp_c = 6'h02 << mux6[1:0];
      end
      pbm_pkg::MODE_P4: begin
        gsh_c  = 3'h2;
        ngrp_c = 6'h01 << mux6[1:0];
      end
      pbm_pkg::MODE_P8: begin
        gsh_c  = 3'h3;
        ngrp_c = 6'h01 << mux6[1:0];
      end
      pbm_pkg::MODE_NIB: begin
        gsh_c  = 3'h2;
        ngrp_c = 6'h04;
      end
      pbm_pkg::MODE_6A, pbm_pkg::MODE_6B: begin
        gsh_c  = 3'h4;
        ngrp_c = mux6[1] ? 6'h02 : 6'h01;
      end
      pbm_pkg::MODE_6E, pbm_pkg::MODE_6F: begin
        gsh_c  = 3'h5;
        ngrp_c = 6'h01;
      end
      default: begin
        gsh_c  = 3'h0;
        ngrp_c = 6'h00;
      end
    endcase
  end

  // Flag picks which nibble of every byte carries pixel data
  wire [15:0] nib_c = flag_s ?
    {pix_s[31:28], pix_s[23:20], pix_s[15:12], pix_s[7:4]} :
    {pix_s[27:24], pix_s[19:16], pix_s[11:8], pix_s[3:0]};

  wire is_vga = mode_c == pbm_pkg::MODE_VGA;

  pbm_pix_if pif ();

  assign pif.load = is_vga ? c0_rise : sc_rise;
  assign pif.dot  = is_vga ? c0_rise : dc_rise;
  assign pif.big  = big & ~is_vga;
  assign pif.gsh  = gsh_c;
  assign pif.ngrp = ngrp_c;
  assign pif.data = is_vga ? {24'h0, vga_s} :
                    (mode_c == pbm_pkg::MODE_NIB) ? {16'h0, nib_c} :
                    pix_s;

  pbm_shifter u_shf (
    .pclk    (pclk),
    .presetn (presetn),
    .sif     (pif.shf)
  );

  // Stage A: controls caught with the pixel
  logic [2:0] a_ctl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      a_ctl_q <= 3'h7;
    else if (pif.dot)
      a_ctl_q <= ctl_s;
  end

  // Stage B: palette address, overlay test and direct colour together
  wire [31:0] p = pif.pix;
  logic [7:0]  raw_c;
  logic [23:0] dir_c;
  logic        pmode_c;

  always_comb begin
    raw_c   = 8'h00;
    dir_c   = 24'h0;
    pmode_c = 1'b1;
    case (mode_c)
      pbm_pkg::MODE_VGA, pbm_pkg::MODE_P8:
        raw_c = p[7:0];
      pbm_pkg::MODE_P1:
        raw_c = {page_q[7:1], p[0]};
      pbm_pkg::MODE_P2:
        raw_c = {page_q[7:2], p[1:0]};
      pbm_pkg::MODE_P4, pbm_pkg::MODE_NIB:
        raw_c = {page_q[7:4], p[3:0]};
      pbm_pkg::MODE_6A: begin
        pmode_c = 1'b0;
        raw_c   = {page_q[7:1], p[15]};
        dir_c   = {p[14:10], 3'h0, p[9:5], 3'h0,
                   p[4:0], 3'h0};
      end
      pbm_pkg::MODE_6B: begin
        pmode_c = 1'b0;
        raw_c   = 8'h00;
        dir_c   = {p[15:11], 3'h0, p[10:5], 2'h0,
                   p[4:0], 3'h0};
      end
      pbm_pkg::MODE_6E: begin
        pmode_c = 1'b0;
        raw_c   = p[31:24];
        dir_c   = {p[23:16], p[15:8], p[7:0]};
      end
      pbm_pkg::MODE_6F: begin
        pmode_c = 1'b0;
        raw_c   = p[7:0];
        dir_c   = {p[15:8], p[23:16], p[31:24]};
      end
      default: begin
        raw_c   = 8'h00;
        dir_c   = 24'h0;
        pmode_c = 1'b0;
      end
    endcase
  end

  wire [7:0] addr_c   = raw_c & mask_q;
  wire       use_pal_c = pmode_c | (addr_c != 8'h00);

  logic [7:0]  b_addr_q;
  logic [23:0] b_dir_q;
  logic        b_pal_q;
  logic [2:0]  b_ctl_q;
  logic        b_vld_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_addr_q <= 8'h00;
      b_dir_q  <= 24'h0;
      b_pal_q  <= 1'b0;
      b_ctl_q  <= 3'h7;
      b_vld_q  <= 1'b0;
    end else begin
      b_vld_q <= pif.pix_vld;
      if (pif.pix_vld) begin
        b_addr_q <= addr_c;
        b_dir_q  <= dir_c;
        b_pal_q  <= use_pal_c;
        b_ctl_q  <= a_ctl_q;
      end
    end
  end

  // Stage C: palette returns in the cycle the address stands
  wire [23:0] pal_adj = w8 ? pal_data :
    {pal_data[21:16], 2'h0, pal_data[13:8], 2'h0,
     pal_data[5:0], 2'h0};
  wire [23:0] col_c = b_pal_q ? pal_adj : b_dir_q;

  logic [23:0] dac_q;
  logic [2:0]  dac_ctl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_q     <= 24'h0;
      dac_ctl_q <= 3'h7;
    end else if (b_vld_q) begin
      dac_q     <= b_ctl_q[2] ? col_c : 24'h0;
      dac_ctl_q <= b_ctl_q;
    end
  end

  assign pal_addr    = b_addr_q;
  assign dac_red     = dac_q[23:16];
  assign dac_green   = dac_q[15:8];
  assign dac_blue    = dac_q[7:0];
  assign dac_blank_n = dac_ctl_q[2];
  assign dac_hsync_n = dac_ctl_q[1];
  assign dac_vsync_n = dac_ctl_q[0];

  // Checks
  logic first_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_vga_wr;
    vga_wr;
  endsequence

  property p_rst_mode;
    first_q |-> (mode_c == pbm_pkg::MODE_VGA && !nib_en);
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("not in pass-through after reset");

  property p_vga_defaults;
    s_vga_wr |=> (gen_q == pbm_pkg::GEN_RST && mask_q == pbm_pkg::MASK_RST
                  && oclk_q == pbm_pkg::OCLK_RST
                  && iclk_q == pbm_pkg::ICLK_RST);
  endproperty
  a_vga_defaults: assert property (p_vga_defaults)
    else $error("defaults not restored on pass-through select");

  property p_vga_mode;
    s_vga_wr |=> (mode_c == pbm_pkg::MODE_VGA);
  endproperty
  a_vga_mode: assert property (p_vga_mode)
    else $error("2Dh write did not enter pass-through");

  property p_vga_path;
    (is_vga && c0_rise) |=> (pif.pix_vld && pif.pix[7:0] == $past(vga_s))
      ##1 (b_vld_q && b_addr_q == ($past(vga_s, 2) & mask_q));
  endproperty
  a_vga_path: assert property (p_vga_path)
    else $error("pass-through byte not taken on first clock");

  property p_nib_only;
    (mode_c == pbm_pkg::MODE_NIB) |->
      (gen_q[pbm_pkg::GEN_SNM] && !gen_q[pbm_pkg::GEN_SPLIT_TRANSFER_ENABLE]);
  endproperty
  a_nib_only: assert property (p_nib_only)
    else $error("nibble mode without its enable");

  property p_nib_over;
    nib_en |-> (mode_c == pbm_pkg::MODE_NIB && ngrp_c == 6'h04);
  endproperty
  a_nib_over: assert property (p_nib_over)
    else $error("nibble mode did not override mux setting");

  property p_page1;
    (pif.pix_vld && mode_c == pbm_pkg::MODE_P1 && $stable(mode_c))
      |=> (b_addr_q == ({page_q[7:1], $past(pif.pix[0])} & mask_q));
  endproperty
  a_page1: assert property (p_page1)
    else $error("mode 1 address not page filled");

  property p_ovl_sel;
    (pif.pix_vld && !pmode_c) |=> (b_pal_q == ($past(addr_c) != 8'h00));
  endproperty
  a_ovl_sel: assert property (p_ovl_sel)
    else $error("overlay selection wrong");

  property p_dir_delay;
    (b_vld_q && !b_pal_q && b_ctl_q[2])
      |=> (dac_q == $past(b_dir_q) && dac_blank_n);
  endproperty
  a_dir_delay: assert property (p_dir_delay)
    else $error("direct colour misaligned with controls");

  property p_565;
    (pif.pix_vld && mode_c == pbm_pkg::MODE_6B)
      |=> (b_dir_q[18:16] == 3'h0 && b_dir_q[9:8] == 2'h0
           && b_dir_q[2:0] == 3'h0 && !b_pal_q);
  endproperty
  a_565: assert property (p_565)
    else $error("5-6-5 low bits not zero");

  property p_mask_zero;
    (pif.pix_vld && mode_c == pbm_pkg::MODE_6A && mask_q == 8'h00)
      |=> !b_pal_q;
  endproperty
  a_mask_zero: assert property (p_mask_zero)
    else $error("zero mask did not force direct colour");
endmodule

/* testbench/pbm_fb_model.sv */
`timescale 1ns/1ps
// Purpose: Frame buffer port, feature connector and palette RAM stand-in.
// Assumes: Pins move just after a pclk edge; clocks 4 high, 4 low.
// Notes:   Once a load is taken the used bits show inverted data.
module pbm_fb_model (
  input  wire logic        pclk,
  input  wire logic [7:0]  pal_addr,
  output logic             shift_clock,
  output logic             pixel_dot_clock,
  output logic             first_clock_input,
  output logic [31:0]      pix_bus,
  output logic [7:0]       vga_bus,
  output logic [23:0]      pal_data
);
  logic [31:0] msk;
  // Same byte on all colours so palette results do not depend on colour order
  assign pal_data = {3{pal_addr}};
  initial begin
    shift_clock = 1'b0;
    pixel_dot_clock = 1'b0;
    first_clock_input = 1'b0;
    pix_bus = 32'h0;
    vga_bus = 8'h0;
    msk = 32'h0;
  end
  task automatic pulse(input logic ld, input logic vga);
    @(posedge pclk);
    shift_clock <= ld & ~vga;
    first_clock_input <= ld & vga;
    pixel_dot_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    shift_clock <= 1'b0;
    first_clock_input <= 1'b0;
    pixel_dot_clock <= 1'b0;
    if (ld) begin
      pix_bus <= ~pix_bus & msk;
      vga_bus <= ~vga_bus;
    end
    repeat (4) @(posedge pclk);
  endtask
  task automatic put(input logic [31:0] d, input int w, input logic vga);
    @(posedge pclk);
    msk = (w >= 32) ? 32'hffffffff : ((32'h1 << w) - 32'h1);
    pix_bus <= d & msk;
    vga_bus <= d[7:0];
    pulse(1'b1, vga);
  endtask
endmodule

/* testbench/test_pixel_bus_mux_modes.sv */
`timescale 1ns/1ps
// Purpose: Self-checking bench of the pixel bus mux block.
// Assumes: One load per row; outputs read 8 pclk after each dot.
// Notes:   Palette rows check pal_addr, direct rows the DAC bytes.
module test_pixel_bus_mux_modes;
  typedef struct {
    logic [7:0] mux, gen, page;
    logic flg;
    logic [31:0] d;
    int w, n;
    logic dac;
    logic [47:0] e;
  } pbm_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, vga_bus, pal_addr, dac_red, dac_green, dac_blue;
  logic [31:0] pwdata, prdata, pix_bus, rd;
  logic [23:0] pal_data;
  logic fci, sclk, dclk, flag, blank_n, hsync_n, vsync_n, bn, hn, vn, er;
  int fail_count, compares, cyc;
  pbm_row_t r;
  pbm_row_t rows [20] = '{
    '{8'h2d, 8'h00, 8'h3c, 0, 32'h5a, 8, 1, 0, 48'h5a},
    '{8'h1c, 8'h00, 8'h3c, 0, 32'ha5, 8, 1, 0, 48'ha5},
    '{8'h1e, 8'h00, 8'h3c, 0, 32'h44332211, 32, 4, 0, 48'h44332211},
    '{8'h1e, 8'h20, 8'h00, 0, 32'h44332211, 32, 4, 0, 48'h11223344},
    '{8'hde, 8'h00, 8'h00, 0, 32'h80ff01fe, 32, 4, 0, 48'h80ff01fe},
    '{8'h1a, 8'h00, 8'h3c, 0, 32'h9c5a, 16, 4, 0, 48'h393c353a},
    '{8'h15, 8'h00, 8'h3c, 0, 32'he4, 8, 4, 0, 48'h3f3e3d3c},
    '{8'h10, 8'h00, 8'h3c, 0, 32'h5, 4, 4, 0, 48'h3c3d3c3d},
    '{8'h1e, 8'h08, 8'h3c, 0, 32'h87654321, 32, 4, 0, 48'h37353331},
    '{8'h1e, 8'h08, 8'h3c, 1, 32'h87654321, 32, 4, 0, 48'h38363432},
    '{8'h1e, 8'h0c, 8'h3c, 1, 32'h87654321, 32, 4, 0, 48'h87654321},
    '{8'h0d, 8'h02, 8'h00, 0, 32'h33221100, 32, 1, 1, 48'h112233},
    '{8'h0e, 8'h02, 8'h00, 0, 32'h00112233, 32, 1, 1, 48'h112233},
    '{8'h0d, 8'h02, 8'h00, 0, 32'h33221105, 32, 1, 1, 48'h050505},
    '{8'h0d, 8'h00, 8'h00, 0, 32'h33221105, 32, 1, 1, 48'h141414},
    '{8'h08, 8'h02, 8'h00, 0, 32'h4104, 16, 1, 1, 48'h804020},
    '{8'h08, 8'h02, 8'h3c, 0, 32'h0, 16, 1, 1, 48'h3c3c3c},
    '{8'h09, 8'h02, 8'h3c, 0, 32'hffff, 16, 1, 1, 48'hf8fcf8},
    '{8'h0a, 8'h02, 8'h00, 0, 32'h7fff4104, 32, 2, 1, 48'hf8f8f8804020},
    '{8'h0b, 8'h02, 8'h00, 0, 32'h0000ffff, 32, 2, 1, 48'h000000f8fcf8}
  };

  pbm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_clock_input(fci), .shift_clock(sclk), .pixel_dot_clock(dclk),
    .split_or_nibble_flag(flag), .pix_bus(pix_bus), .vga_bus(vga_bus),
    .blank_n(blank_n), .hsync_n(hsync_n), .vsync_n(vsync_n),
    .pal_data(pal_data), .pal_addr(pal_addr), .dac_red(dac_red),
    .dac_green(dac_green), .dac_blue(dac_blue), .dac_blank_n(bn),
    .dac_hsync_n(hn), .dac_vsync_n(vn));
  pbm_fb_model fb_u (.pclk(pclk), .pal_addr(pal_addr), .shift_clock(sclk),
    .pixel_dot_clock(dclk), .first_clock_input(fci), .pix_bus(pix_bus),
    .vga_bus(vga_bus), .pal_data(pal_data));

  task automatic chk(input string nm, input logic [47:0] s,
                     input logic [47:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Register file as software sees it; page survives pass-through
  task automatic chk_regs(input logic [7:0] pg);
    logic [7:0] a [7];
    logic [7:0] e [7];
    a = '{pbm_pkg::OFF_MUX, pbm_pkg::OFF_GEN, pbm_pkg::OFF_PAGE,
          pbm_pkg::OFF_MASK, pbm_pkg::OFF_ICLK, pbm_pkg::OFF_OCLK,
          pbm_pkg::OFF_STAT};
    e = '{pbm_pkg::MUX_RST, pbm_pkg::GEN_RST, pg, pbm_pkg::MASK_RST,
          pbm_pkg::ICLK_RST, pbm_pkg::OCLK_RST, 8'h01};
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, a[i], 8'h00);
      chk("reg", {16'h0, rd}, {40'h0, e[i]});
    end
  endtask
  task end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, flag, hsync_n} = '0;
    {blank_n, vsync_n} = 2'b11;
    {paddr, pwdata, fail_count, compares, cyc} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk_regs(pbm_pkg::PAGE_RST);
    apb(1'b0, 8'h1c, 8'h00);
    chk("unmapped", {46'h0, er, |rd}, 48'h2);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, pbm_pkg::OFF_MUX, r.mux);
      apb(1'b1, pbm_pkg::OFF_GEN, r.gen);
      apb(1'b1, pbm_pkg::OFF_PAGE, r.page);
      flag <= r.flg;
      fb_u.put(r.d, r.w, r.mux == 8'h2d);
      for (int k = 0; k < r.n; k++) begin
        if (k > 0)
          fb_u.pulse(1'b0, 1'b0);
        #1;
        if (r.dac)
          chk("dac", {24'h0, dac_red, dac_green, dac_blue},
              {24'h0, r.e[24*k +: 24]});
        else
          chk("pal_addr", {40'h0, pal_addr},
              {40'h0, r.e[8*k +: 8]});
      end
    end
    chk("sync", {45'h0, bn, hn, vn}, 48'h5);
    // Cleared read mask forces direct colour despite a nonzero page
    apb(1'b1, pbm_pkg::OFF_MASK, 8'h00);
    apb(1'b1, pbm_pkg::OFF_MUX, 8'h08);
    apb(1'b1, pbm_pkg::OFF_PAGE, 8'h3c);
    fb_u.put(32'h4104, 16, 1'b0);
    #1;
    chk("mask", {24'h0, dac_red, dac_green, dac_blue}, 48'h804020);
    apb(1'b1, pbm_pkg::OFF_GEN, 8'h22);
    // Blanking zeroes the colour and travels with the syncs
    blank_n <= 1'b0;
    hsync_n <= 1'b1;
    fb_u.put(32'h4104, 16, 1'b0);
    #1;
    chk("blank", {21'h0, bn, hn, vn, dac_red, dac_green, dac_blue},
        48'h3000000);
    apb(1'b1, pbm_pkg::OFF_OCLK, 8'h12);
    apb(1'b1, pbm_pkg::OFF_ICLK, 8'h01);
    // Reserved code must read back as the invalid mode
    apb(1'b1, pbm_pkg::OFF_MUX, 8'h1f);
    apb(1'b0, pbm_pkg::OFF_STAT, 8'h00);
    chk("status", {16'h0, rd}, 48'h400);
    apb(1'b1, pbm_pkg::OFF_MUX, 8'h2d);
    chk_regs(8'h3c);
    end_of_test();
  end
endmodule
